// *** inc/event_card_pkg.sv ***
package event_card_pkg;
   localparam int unsigned width_c = 16;
   localparam logic [11:0] off_ctrl = 12'h000;
   localparam logic [11:0] off_data = 12'h004;
   localparam logic [11:0] off_status = 12'h008;
   localparam logic [11:0] off_int_status = 12'h00C;
   localparam logic [11:0] off_int_clear = 12'h010;
   localparam logic [11:0] off_int_enable = 12'h014;
   localparam logic [11:0] off_point_mask = 12'h018;
   localparam logic [11:0] off_base = 12'h01C;
   // card address field lives in paddr[19:12]
   localparam int unsigned card_lo = 12;
   localparam int unsigned card_hi = 19;
   localparam logic [7:0] card_addr_def = 8'h01;
   localparam logic [31:0] data_zero = 32'h0000_0000;
   localparam logic [15:0] word_ones = 16'hFFFF;
   localparam logic [15:0] mask_rst = 16'hFFFF;
   // ctrl bit positions
   localparam int unsigned ctrl_mode_lo = 0;
   localparam int unsigned ctrl_force = 2;
   // int status bit positions
   localparam int unsigned ev_edge = 0;
   localparam int unsigned ev_sync = 1;
   localparam int unsigned ev_overrun = 2;
   localparam int unsigned ev_w = 3;

   typedef enum logic [1:0] {
      mode_plain = 2'b00,
      mode_edge = 2'b01,
      mode_sync = 2'b10,
      mode_diag = 2'b11
   } mode_t;

   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_armed = 3'b010,
      st_pending = 3'b100
   } state_t;

   typedef struct packed {
      logic [15:0] word;
      logic strobe;
   } user_in_t;
endpackage

// *** hw/input_sync.sv ***
`timescale 1ns/1ps
module input_sync
   import event_card_pkg::*;
#(
   parameter int unsigned w = 17
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [w-1:0] async_in,
   output logic [w-1:0] level_out,
   output logic [w-1:0] rise_out
);
   logic [w-1:0] s1_reg;
   logic [w-1:0] s2_reg;
   logic [w-1:0] s3_reg;
   logic [w-1:0] level_reg;
   logic [w-1:0] level_next;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts once stages two and three agree
   assign level_next = (s2_reg & s3_reg) | (level_reg & (s2_reg | s3_reg));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= '0;
      end else begin
         level_reg <= level_next;
      end
   end

   // the agreed level of this edge, so a rise and its data word are seen together
   assign level_out = level_next;
   assign rise_out = level_next & ~level_reg;
endmodule // input_sync

// *** hw/event_card.sv ***
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module event_card
   import event_card_pkg::*;
#(
   parameter logic [7:0] card_addr = card_addr_def
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire user_in_t user_in,
   output logic sync_ready,
   output logic irq
);
   logic [16:0] sync_level;
   logic [16:0] sync_rise;
   logic [15:0] live_word;
   logic strobe_rise;
   mode_t mode_reg;
   logic force_reg;
   logic [15:0] mask_reg;
   logic [15:0] hold_reg;
   logic [ev_w-1:0] int_status_reg;
   logic [ev_w-1:0] int_enable_reg;
   state_t state_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic sync_ready_reg;
   logic irq_reg;
   logic ours;
   logic acc;
   logic wr;
   logic rd;
   logic [11:0] off;
   logic mapped;
   logic data_read;
   logic [15:0] diag_word;
   logic [15:0] edge_hit;
   logic edge_ev;
   logic sync_ev;
   logic overrun_ev;
   logic [ev_w-1:0] set_bits;
   logic [ev_w-1:0] clr_bits;

   input_sync #(.w(17)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({user_in.strobe, user_in.word}),
      .level_out(sync_level),
      .rise_out(sync_rise)
   );

   assign live_word = sync_level[15:0];
   assign strobe_rise = sync_rise[16];

   function automatic logic is_off(input logic [11:0] a, input logic [11:0] b);
      return a == b;
   endfunction

   // one word per access, only at our card address
   assign ours = paddr[card_hi:card_lo] == card_addr;
   assign acc = psel && penable && ours && !pready_reg;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign off = paddr[11:0];
   assign mapped = off < off_base && off[1:0] == 2'b00;
   assign data_read = rd && is_off(off, off_data);
   assign diag_word = force_reg ? word_ones : 16'h0000;

   assign edge_hit = sync_rise[15:0] & mask_reg;
   assign edge_ev = mode_reg == mode_edge && |edge_hit;
   assign sync_ev = mode_reg == mode_sync && strobe_rise;
   assign overrun_ev = sync_ev && !sync_ready_reg;
   assign set_bits = {overrun_ev, sync_ev, edge_ev};
   assign clr_bits = (wr && is_off(off, off_int_clear)) ? pwdata[ev_w-1:0] : '0;

   // mode changes only by software; one mode at a time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= mode_plain;
         force_reg <= 1'b0;
      end else if (wr && is_off(off, off_ctrl)) begin
         mode_reg <= mode_t'(pwdata[ctrl_mode_lo +: 2]);
         force_reg <= pwdata[ctrl_force];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= mask_rst;
         int_enable_reg <= '0;
      end else begin
         if (wr && is_off(off, off_point_mask)) begin
            mask_reg <= pwdata[15:0];
         end
         if (wr && is_off(off, off_int_enable)) begin
            int_enable_reg <= pwdata[ev_w-1:0];
         end
      end
   end

   // captured word: edges latch live data, strobes latch the user word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= '0;
      end else if (edge_ev) begin
         hold_reg <= live_word;
      end else if (sync_ev && sync_ready_reg) begin
         hold_reg <= live_word;
      end
   end

   // sticky events; a set in the same cycle beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status_reg <= '0;
      end else begin
         int_status_reg <= (int_status_reg & ~clr_bits) | set_bits;
      end
   end

   // pending state: released by reading the data word or by clearing the edge or sync event bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= st_idle;
      end else begin
         unique case (state_reg)
            st_idle: begin
               if (mode_reg == mode_edge || mode_reg == mode_sync) begin
                  state_reg <= st_armed;
               end
            end
            st_armed: begin
               if (edge_ev || (sync_ev && sync_ready_reg)) begin
                  state_reg <= st_pending;
               end else if (mode_reg == mode_plain || mode_reg == mode_diag) begin
                  state_reg <= st_idle;
               end
            end
            st_pending: begin
               if (data_read || |clr_bits[ev_sync:ev_edge]) begin
                  state_reg <= st_armed;
               end else if (mode_reg == mode_plain || mode_reg == mode_diag) begin
                  state_reg <= st_idle;
               end
            end
            default: state_reg <= st_idle;
         endcase
      end
   end

   // ready for a new user word only while armed in strobed mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_ready_reg <= 1'b0;
      end else begin
         sync_ready_reg <= mode_reg == mode_sync && state_reg == st_armed
            && !sync_ev;
      end
   end

   // plain mode never interrupts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= mode_reg != mode_plain && mode_reg != mode_diag
            && |(int_status_reg & int_enable_reg);
      end
   end

   // apb slave: one wait state per access phase, pready one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= data_zero;
      end else begin
         pready_reg <= acc;
         pslverr_reg <= acc && !mapped;
         prdata_reg <= data_zero;
         if (rd) begin
            unique case (1'b1)
               is_off(off, off_ctrl):
                  prdata_reg <= {29'h0, force_reg, mode_reg};
               is_off(off, off_data): begin
                  if (mode_reg == mode_diag) begin
                     prdata_reg <= {16'h0, diag_word};
                  end else if (mode_reg == mode_plain) begin
                     prdata_reg <= {16'h0, live_word};
                  end else begin
                     prdata_reg <= {16'h0, hold_reg};
                  end
               end
               is_off(off, off_status):
                  prdata_reg <= {24'h0, sync_ready_reg, state_reg, force_reg,
                     mode_reg, irq_reg};
               is_off(off, off_int_status):
                  prdata_reg <= {29'h0, int_status_reg};
               is_off(off, off_int_enable):
                  prdata_reg <= {29'h0, int_enable_reg};
               is_off(off, off_point_mask):
                  prdata_reg <= {16'h0, mask_reg};
               default: prdata_reg <= data_zero;
            endcase
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign sync_ready = sync_ready_reg;
   assign irq = irq_reg;

   plain_no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_reg == mode_plain |=> !irq_reg) else $error("irq in plain mode");
   edge_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      edge_ev |=> int_status_reg[ev_edge]) else $error("edge lost");
   edge_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      edge_ev |=> hold_reg == $past(live_word)) else $error("latch wrong");
   sync_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      sync_ev |=> int_status_reg[ev_sync] && !sync_ready_reg) else $error("sync lost");
   ready_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      sync_ready_reg |-> $past(mode_reg) == mode_sync) else $error("ready wrong");
   diag_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      data_read && mode_reg == mode_diag |=> prdata_reg[15:0] == $past(diag_word))
      else $error("diag data wrong");
   foreign_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !ours |=> !pready_reg) else $error("foreign answered");
   one_word_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready_reg |=> !pready_reg) else $error("pready held");
   pend_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == st_pending && !data_read && clr_bits == '0
      && mode_reg inside {mode_edge, mode_sync} |=> state_reg == st_pending)
      else $error("pending dropped");
   mode_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(mode_reg) |-> $past(wr) && $past(off) == off_ctrl)
      else $error("mode changed alone");
endmodule // event_card

// *** verification/field_source.sv ***
`timescale 1ns/1ps
module field_source
   import event_card_pkg::*;
#(
   parameter int hold = 6
) (
   input wire logic pclk,
   input wire logic [15:0] level,
   input wire logic send,
   output user_in_t user_in,
   output logic busy
);
   int cnt = 0;
   // field levels are wired straight through, no latching on this side
   // one strobe pulse of hold cycles per word, then hold cycles low
   assign user_in = '{word: level, strobe: (cnt > hold)};
   assign busy = cnt != 0;
   always @(posedge pclk) begin
      if (send)
         cnt <= 2 * hold;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule // field_source

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
   import event_card_pkg::*;
;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, sync_ready, irq, busy, err;
   logic send = 0;
   logic [15:0] level = '0;
   logic [31:0] r;
   user_in_t user_in;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #10 pclk = ~pclk;

   event_card dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .user_in(user_in),
      .sync_ready(sync_ready), .irq(irq));
   field_source far (.pclk(pclk), .level(level), .send(send), .user_in(user_in),
      .busy(busy));

   task automatic give_verdict;
      if (num_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // only the bench timeout ends this wait
   task automatic apb(logic w, logic [7:0] c, logic [11:0] o, logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {12'h000, c, o};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      err = pslverr;
      r = prdata;
      psel <= 0;
      penable <= 0;
   endtask

   // a foreign card address is never answered; the access is dropped after a while
   task automatic foreign(logic [11:0] o);
      int seen = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= 0;
      paddr <= {12'h000, 8'h02, o};
      @(posedge pclk);
      penable <= 1;
      repeat (8) begin
         @(posedge pclk);
         if (pready !== 1'b0)
            seen++;
      end
      psel <= 0;
      penable <= 0;
      chk("foreign", 32'h0, 32'(seen));
   endtask

   task automatic wr(logic [11:0] o, logic [31:0] d);
      apb(1, card_addr_def, o, d);
   endtask

   task automatic rd(string n, logic [11:0] o, logic [31:0] e);
      apb(0, card_addr_def, o, 32'h0000_0000);
      chk(n, e, r);
   endtask

   task automatic idle(int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic wirq(logic e);
      int n = 0;
      while (irq !== e && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask

   task automatic pulse;
      int n = 0;
      send <= 1;
      @(posedge pclk);
      send <= 0;
      do begin
         @(posedge pclk);
         n++;
      end while (busy !== 1'b0 && n < 40);
   endtask

   task automatic t_regs;
      rd("ctrl", off_ctrl, 32'h0000_0000);
      rd("mask", off_point_mask, 32'h0000_FFFF);
      chk("pslverr", 32'h0, {31'h0, err});
      rd("int_en", off_int_enable, 32'h0000_0000);
      rd("int_st", off_int_status, 32'h0000_0000);
      rd("unmapped", off_base, 32'h0000_0000);
      chk("pslverr", 32'h1, {31'h0, err});
      foreign(off_ctrl);
   endtask

   task automatic t_plain;
      wr(off_int_enable, 32'h0000_0003);
      level <= 16'hA5A5;
      idle(10);
      rd("plain", off_data, 32'h0000_A5A5);
      level <= 16'h5A5A;
      idle(10);
      rd("plain", off_data, 32'h0000_5A5A);
      chk("irq", 32'h0, {31'h0, irq});
      wr(off_int_enable, 32'h0000_0000);
   endtask

   task automatic t_edge;
      level <= 16'h0000;
      wr(off_ctrl, 32'h0000_0001);
      wr(off_int_clear, 32'h0000_0007);
      wr(off_int_enable, 32'h0000_0001);
      level <= 16'h0008;
      wirq(1);
      rd("int_st", off_int_status, 32'h0000_0001);
      level <= 16'h0000;
      idle(10);
      rd("held", off_data, 32'h0000_0008);
      wr(off_int_clear, 32'h0000_0001);
      wirq(0);
      wr(off_point_mask, 32'h0000_FFF7);
      level <= 16'h0008;
      idle(12);
      rd("masked", off_int_status, 32'h0000_0000);
      wr(off_point_mask, 32'h0000_FFFF);
      wr(off_int_enable, 32'h0000_0000);
      level <= 16'h0009;
      idle(12);
      chk("irq", 32'h0, {31'h0, irq});
      rd("int_st", off_int_status, 32'h0000_0001);
      wr(off_int_enable, 32'h0000_0001);
      wirq(1);
      wr(off_int_clear, 32'h0000_0001);
      wirq(0);
   endtask

   task automatic t_sync;
      wr(off_int_clear, 32'h0000_0007);
      wr(off_ctrl, 32'h0000_0002);
      wr(off_int_enable, 32'h0000_0002);
      level <= 16'h1234;
      idle(3);
      chk("ready", 32'h1, {31'h0, sync_ready});
      pulse();
      wirq(1);
      rd("status", off_status, 32'h0000_0045);
      chk("ready", 32'h0, {31'h0, sync_ready});
      level <= 16'h4321;
      pulse();
      rd("overrun", off_int_status, 32'h0000_0006);
      rd("held", off_data, 32'h0000_1234);
      idle(2);
      chk("ready", 32'h1, {31'h0, sync_ready});
      wr(off_int_clear, 32'h0000_0007);
      wirq(0);
   endtask

   task automatic t_diag;
      wr(off_int_enable, 32'h0000_0000);
      for (int m = 0; m < 4; m++) begin
         wr(off_ctrl, 32'(m));
         apb(0, card_addr_def, off_status, 32'h0000_0000);
         chk("mode", 32'(m), {30'h0, r[2:1]});
      end
      wr(off_int_enable, 32'h0000_0003);
      level <= 16'hFFFF;
      idle(10);
      rd("diag0", off_data, 32'h0000_0000);
      chk("irq", 32'h0, {31'h0, irq});
      wr(off_ctrl, 32'h0000_0007);
      level <= 16'h0000;
      idle(10);
      rd("diag1", off_data, 32'h0000_FFFF);
      apb(0, card_addr_def, off_status, 32'h0000_0000);
      chk("force", 32'h0000_000E, {28'h0, r[3:0]});
   endtask

   // 20000 cycles is far beyond the few hundred the scenarios need
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      t_regs();
      t_plain();
      t_edge();
      t_sync();
      t_diag();
      give_verdict();
   end
endmodule // tb_top
